// >>> verilog/pfrl_link.sv
// Top of the fault report link: event filters, priority, duty-cycle
// line, acknowledge detection, driver enable and a Wishbone slave.
// Assumes fault inputs, supply, enable and the line are asynchronous.
`timescale 1ns/100ps
`include "pfrl_defs.svh"

module pfrl_link #(
  parameter int SLOW_PERIOD_CYC = `PFRL_SLOW_PERIOD_CYC,
  parameter int FAST_PERIOD_CYC = `PFRL_FAST_PERIOD_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Raw fault conditions
  input wire logic gate_supply_high,
  input wire logic boost_supply_low,
  input wire logic gate_source_low,
  input wire logic gate_supply_low,
  input wire logic overtemp_warning,
  input wire logic main_supply_low,
  input wire logic main_supply_high,
  input wire logic logic_supply_low,
  input wire logic config_mem_double_error,
  input wire logic drain_source_fault,
  // Supply and enable
  input wire logic logic_supply_on,
  input wire logic driver_enable_in,
  // Open-drain diagnostic line
  input wire logic diag_line_i,
  output logic diag_line_o,
  output logic diag_line_oe,
  // Gate drivers
  output logic gate_drive_en
);

  localparam int NEV = `PFRL_NUM_EV;
  localparam int NSY = NEV + 3;

  // Debounce limit per event; drain-source adds its blanking time
  function automatic logic [15:0] deb_limit(input int idx, input logic [1:0] blank);
    logic [15:0] lim;
    lim = 16'(`PFRL_DEB_SHORT_CYC);
    case (idx)
      `PFRL_EV_BOOST, `PFRL_EV_GSUP: lim = 16'(`PFRL_DEB_LONG_CYC);
      `PFRL_EV_MSL, `PFRL_EV_LSL: lim = 16'(`PFRL_DEB_MID_CYC);
      `PFRL_EV_MEM: lim = 16'h0000;
      `PFRL_EV_DS:
      begin
        case (blank)
          2'h0: lim = 16'(`PFRL_DEB_SHORT_CYC + `PFRL_NS2CYC(`PFRL_BLANK0_NS));
          2'h1: lim = 16'(`PFRL_DEB_SHORT_CYC + `PFRL_NS2CYC(`PFRL_BLANK1_NS));
          2'h2: lim = 16'(`PFRL_DEB_SHORT_CYC + `PFRL_NS2CYC(`PFRL_BLANK2_NS));
          default: lim = 16'(`PFRL_DEB_SHORT_CYC + `PFRL_NS2CYC(`PFRL_BLANK3_NS));
        endcase
      end
      default: lim = 16'(`PFRL_DEB_SHORT_CYC);
    endcase
    return lim;
  endfunction

  // Duty code per event index
  function automatic logic [9:0] duty_of(input logic [3:0] idx);
    logic [9:0] d;
    d = `PFRL_DUTY_GSH;
    case (idx)
      4'h1: d = `PFRL_DUTY_BOOST;
      4'h2: d = `PFRL_DUTY_GSL;
      4'h3: d = `PFRL_DUTY_GSUP;
      4'h4: d = `PFRL_DUTY_OVT;
      4'h5: d = `PFRL_DUTY_MSL;
      4'h6: d = `PFRL_DUTY_MSH;
      4'h7: d = `PFRL_DUTY_LSL;
      4'h8: d = `PFRL_DUTY_MEM;
      4'h9: d = `PFRL_DUTY_DS;
      default: d = `PFRL_DUTY_GSH;
    endcase
    return d;
  endfunction

  // Lowest set index wins
  function automatic logic [3:0] first_set(input logic [NEV-1:0] v);
    logic [3:0] f;
    f = 4'h0;
    for (int i = NEV - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        f = 4'(i);
      end
    end
    return f;
  endfunction

  // Two-stage synchronisers for every asynchronous input
  logic [NSY-1:0] async_in;
  logic [NSY-1:0] sync1_ff;
  logic [NSY-1:0] sync2_ff;
  assign async_in = {diag_line_i, driver_enable_in, logic_supply_on,
    drain_source_fault, config_mem_double_error, logic_supply_low,
    main_supply_high, main_supply_low, overtemp_warning, gate_supply_low,
    gate_source_low, boost_supply_low, gate_supply_high};

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sync1_ff <= {1'b1, 1'b0, 1'b1, {NEV{1'b0}}}; // Idle levels: no false sleep or edge
      sync2_ff <= {1'b1, 1'b0, 1'b1, {NEV{1'b0}}};
    end
    else
    begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
    end
  end

  logic sup_on;
  logic en_sync;
  logic line_low;
  assign sup_on = sync2_ff[NEV];
  assign en_sync = sync2_ff[NEV+1];
  assign line_low = !sync2_ff[NEV+2];

  // Configuration register
  logic [6:0] cfg_ff;
  logic [6:0] nxt_cfg;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic ack_bus_ff;
  logic nxt_ack_bus;

  // Monitor enables mask the raw condition before filtering
  logic [NEV-1:0] raw_masked;
  logic [NEV-1:0] deb;
  always_comb
  begin
    raw_masked = sync2_ff[NEV-1:0];
    raw_masked[`PFRL_EV_DS] = sync2_ff[`PFRL_EV_DS] && cfg_ff[`PFRL_CFG_DS_EN];
    raw_masked[`PFRL_EV_GSL] = sync2_ff[`PFRL_EV_GSL] && cfg_ff[`PFRL_CFG_GS_EN];
  end

  // One filter per event
  genvar gi;
  generate
    for (gi = 0; gi < NEV; gi++)
    begin : g_deb
      pfrl_debounce u_deb (
        .clk_sys(clk_sys),
        .reset(reset),
        .raw(raw_masked[gi]),
        .limit(deb_limit(gi, cfg_ff[`PFRL_CFG_BLANK_LO+1:`PFRL_CFG_BLANK_LO])),
        .level(deb[gi])
      );
    end
  endgenerate

  // Link state
  pfrl_pkg::pfrl_state_t state_ff;
  pfrl_pkg::pfrl_state_t nxt_state;
  logic [NEV-1:0] deb_prev_ff;
  logic [NEV-1:0] pend_ff;
  logic [NEV-1:0] nxt_pend;
  logic [3:0] cur_ff;
  logic [3:0] nxt_cur;
  logic trip_ff;
  logic nxt_trip;
  pfrl_pkg::pfrl_cnt_t ack_cnt_ff;
  pfrl_pkg::pfrl_cnt_t nxt_ack_cnt;
  logic oe_ff;
  logic nxt_oe;
  logic drv_ff;
  logic nxt_drv;
  logic restart;
  logic ack_hit;
  logic low_phase;
  logic [NEV-1:0] rise;
  logic [NEV-1:0] cur_mask;
  logic [NEV-1:0] rest;
  pfrl_pkg::pfrl_cnt_t period_cyc;
  pfrl_pkg::pfrl_cnt_t high_cyc;
  logic [33:0] high_prod;
  logic [9:0] duty;

  assign rise = deb & ~deb_prev_ff;
  assign cur_mask = NEV'(1) << cur_ff;
  assign rest = pend_ff & ~cur_mask;

  // Period by rate bit, high time from the duty code
  assign period_cyc = cfg_ff[`PFRL_CFG_RATE] ? 24'(FAST_PERIOD_CYC) : 24'(SLOW_PERIOD_CYC);
  assign duty = (state_ff == pfrl_pkg::ST_EOF) ? `PFRL_DUTY_EOF : duty_of(cur_ff);
  assign high_prod = (34'(period_cyc) * 34'(duty)) / 34'd1000;
  assign high_cyc = high_prod[23:0];

  pfrl_pwm_gen u_pwm (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(state_ff != pfrl_pkg::ST_IDLE),
    .restart(restart),
    .period_cyc(period_cyc),
    .high_cyc(high_cyc),
    .low_phase(low_phase),
    .period_end()
  );

  // Low time measured from the falling edge; saturates so one hold acks once
  always_comb
  begin
    nxt_ack_cnt = 24'h000000;
    if (line_low)
    begin
      nxt_ack_cnt = (ack_cnt_ff > period_cyc) ? ack_cnt_ff : ack_cnt_ff + 24'h000001;
    end
  end
  assign ack_hit = line_low && (ack_cnt_ff == period_cyc);

  // Sequencing, pending flags, trip latch and line drive
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_pend = pend_ff;
    nxt_trip = trip_ff;
    restart = 1'b0;
    case (state_ff)
      pfrl_pkg::ST_IDLE:
      begin
        if (pend_ff != '0)
        begin
          nxt_state = pfrl_pkg::ST_SEND;
          nxt_cur = first_set(pend_ff);
          restart = 1'b1;
        end
      end
      pfrl_pkg::ST_SEND:
      begin
        if (ack_hit)
        begin
          nxt_pend = rest;
          restart = 1'b1;
          if (rest != '0)
          begin
            nxt_cur = first_set(rest);
          end
          else
          begin
            nxt_state = pfrl_pkg::ST_EOF;
          end
        end
      end
      default:
      begin
        if (ack_hit)
        begin
          restart = 1'b1;
          if (pend_ff != '0)
          begin
            nxt_state = pfrl_pkg::ST_SEND;
            nxt_cur = first_set(pend_ff);
          end
          else if (deb == '0)
          begin
            nxt_state = pfrl_pkg::ST_IDLE;
          end
        end
      end
    endcase
    // Acknowledge releases a protective trip
    if (ack_hit)
    begin
      nxt_trip = 1'b0;
    end
    // New events set flags; a set in the clearing cycle still wins
    nxt_pend = nxt_pend | rise;
    if (rise[`PFRL_EV_MSH] || rise[`PFRL_EV_GSH] && cfg_ff[`PFRL_CFG_GSH_TRIP]
        || rise[`PFRL_EV_DS] && cfg_ff[`PFRL_CFG_DS_TRIP])
    begin
      nxt_trip = 1'b1;
    end
    // Sleep: state, pending flags and trip forgotten, line pulled low
    if (!sup_on)
    begin
      nxt_state = pfrl_pkg::ST_IDLE;
      nxt_pend = '0;
      nxt_trip = 1'b0;
    end
    nxt_oe = !sup_on || (state_ff != pfrl_pkg::ST_IDLE && low_phase);
    nxt_drv = sup_on && en_sync && !trip_ff;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= pfrl_pkg::ST_IDLE;
      cur_ff <= 4'h0;
      pend_ff <= '0;
      deb_prev_ff <= '0;
      trip_ff <= 1'b0;
      ack_cnt_ff <= 24'h000000;
      oe_ff <= 1'b0;
      drv_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cur_ff <= nxt_cur;
      pend_ff <= nxt_pend;
      deb_prev_ff <= deb;
      trip_ff <= nxt_trip;
      ack_cnt_ff <= nxt_ack_cnt;
      oe_ff <= nxt_oe;
      drv_ff <= nxt_drv;
    end
  end

  // Wishbone: one wait state, unmapped reads return zero
  always_comb
  begin
    nxt_cfg = cfg_ff;
    nxt_rdat = 32'h00000000;
    nxt_ack_bus = wb_cyc_i && wb_stb_i && !ack_bus_ff;
    if (nxt_ack_bus)
    begin
      if (wb_adr_i == `PFRL_ADR_CONFIG)
      begin
        nxt_rdat = {25'h0000000, cfg_ff};
        if (wb_we_i && wb_sel_i[0])
        begin
          nxt_cfg = wb_dat_i[6:0];
        end
      end
      else if (wb_adr_i == `PFRL_ADR_STATUS)
      begin
        nxt_rdat = {8'h00, state_ff, drv_ff, trip_ff, deb, pend_ff};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cfg_ff <= `PFRL_CFG_RESET;
      rdat_ff <= 32'h00000000;
      ack_bus_ff <= 1'b0;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
      rdat_ff <= nxt_rdat;
      ack_bus_ff <= nxt_ack_bus;
    end
  end

  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_bus_ff;
  assign diag_line_o = 1'b0;
  assign diag_line_oe = oe_ff;
  assign gate_drive_en = drv_ff;

  // Checks
  logic idle_on;
  assign idle_on = sup_on && (state_ff == pfrl_pkg::ST_IDLE);

  idle_line_high_a: assert property (@(posedge clk_sys) disable iff (reset)
    idle_on |=> !diag_line_oe)
    else $error("line pulled low while idle");

  sleep_line_low_a: assert property (@(posedge clk_sys) disable iff (reset)
    !sup_on |=> diag_line_oe && state_ff == pfrl_pkg::ST_IDLE)
    else $error("line not low in sleep");

  drv_off_input_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!sup_on || !en_sync) |=> !gate_drive_en)
    else $error("drivers on during sleep or enable low");

  trip_off_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(trip_ff) |-> ##1 !gate_drive_en [*2])
    else $error("drivers on after protective trip");

  ds_mask_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!cfg_ff[`PFRL_CFG_DS_EN] && !pend_ff[`PFRL_EV_DS] && !deb[`PFRL_EV_DS])
    |=> !pend_ff[`PFRL_EV_DS])
    else $error("masked drain-source fault reported");

  set_wins_a: assert property (@(posedge clk_sys) disable iff (reset)
    (rise != '0 && sup_on) |=> ((pend_ff & $past(rise)) == $past(rise)))
    else $error("fault event lost");

  code_repeat_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_ff == pfrl_pkg::ST_SEND && !ack_hit && sup_on)
    |=> state_ff == pfrl_pkg::ST_SEND && $stable(cur_ff))
    else $error("code changed without acknowledge");

  eof_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_ff == pfrl_pkg::ST_SEND && ack_hit && rest == '0 && rise == '0 && sup_on)
    |=> state_ff == pfrl_pkg::ST_EOF)
    else $error("end-of-frame not sent after last fault");

  idle_only_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_ff != pfrl_pkg::ST_IDLE && sup_on && !(state_ff == pfrl_pkg::ST_EOF && ack_hit
    && deb == '0)) |=> state_ff != pfrl_pkg::ST_IDLE)
    else $error("idle entered without acknowledged end-of-frame");

endmodule

// >>> verilog/pfrl_defs.svh
// Constants of the fault report link: offsets, reset values, field
// positions, duty codes and timing. Included by the top module and the testbench.
`ifndef PFRL_DEFS_SVH
`define PFRL_DEFS_SVH

// Clock rate
`define PFRL_CLK_MHZ 125

// Register offsets (byte addresses)
`define PFRL_ADR_CONFIG 8'h00
`define PFRL_ADR_STATUS 8'h04

// Config fields and reset value
`define PFRL_CFG_RATE 0
`define PFRL_CFG_DS_EN 1
`define PFRL_CFG_GS_EN 2
`define PFRL_CFG_BLANK_LO 3
`define PFRL_CFG_GSH_TRIP 5
`define PFRL_CFG_DS_TRIP 6
`define PFRL_CFG_RESET 7'h76

// Event indices, equal to priority minus one
`define PFRL_EV_GSH 0
`define PFRL_EV_BOOST 1
`define PFRL_EV_GSL 2
`define PFRL_EV_GSUP 3
`define PFRL_EV_OVT 4
`define PFRL_EV_MSL 5
`define PFRL_EV_MSH 6
`define PFRL_EV_LSL 7
`define PFRL_EV_MEM 8
`define PFRL_EV_DS 9
`define PFRL_NUM_EV 10

// Duty cycles in tenths of a percent
`define PFRL_DUTY_EOF 10'd935
`define PFRL_DUTY_DS 10'd825
`define PFRL_DUTY_MEM 10'd550
`define PFRL_DUTY_LSL 10'd495
`define PFRL_DUTY_MSH 10'd440
`define PFRL_DUTY_MSL 10'd385
`define PFRL_DUTY_OVT 10'd330
`define PFRL_DUTY_GSUP 10'd275
`define PFRL_DUTY_GSL 10'd220
`define PFRL_DUTY_BOOST 10'd165
`define PFRL_DUTY_GSH 10'd110

// Debounce times in microseconds and their cycle counts
`define PFRL_DEB_SHORT_US 2
`define PFRL_DEB_MID_US 8
`define PFRL_DEB_LONG_US 16
`define PFRL_DEB_SHORT_CYC (`PFRL_DEB_SHORT_US * `PFRL_CLK_MHZ)
`define PFRL_DEB_MID_CYC (`PFRL_DEB_MID_US * `PFRL_CLK_MHZ)
`define PFRL_DEB_LONG_CYC (`PFRL_DEB_LONG_US * `PFRL_CLK_MHZ)

// Drain-source blanking choices in ns, rounded up to cycles
`define PFRL_BLANK0_NS 500
`define PFRL_BLANK1_NS 1000
`define PFRL_BLANK2_NS 2000
`define PFRL_BLANK3_NS 4000
`define PFRL_NS2CYC(t) (((t) * `PFRL_CLK_MHZ + 999) / 1000)

// Line periods in microseconds and their cycle counts
`define PFRL_SLOW_PERIOD_US 1000
`define PFRL_FAST_PERIOD_US 100
`define PFRL_SLOW_PERIOD_CYC (`PFRL_SLOW_PERIOD_US * `PFRL_CLK_MHZ)
`define PFRL_FAST_PERIOD_CYC (`PFRL_FAST_PERIOD_US * `PFRL_CLK_MHZ)

`endif

// >>> verilog/pfrl_pkg.sv
// Types of the fault report link.
// Assumes nothing beyond a SystemVerilog compiler.
package pfrl_pkg;

  // Link sequencing states
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_EOF} pfrl_state_t;

  // Width of period and duty counters
  typedef logic [23:0] pfrl_cnt_t;

endpackage

// >>> verilog/pfrl_debounce.sv
// Debounce filter for one fault condition.
// Assumes a raw input already synchronised to clk_sys.
`timescale 1ns/100ps
module pfrl_debounce (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Filter
  input wire logic raw,
  input wire logic [15:0] limit,
  output logic level
);

  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic level_ff;
  logic nxt_level;

  // Counter restarts whenever the condition drops
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_level = level_ff;
    if (!raw)
    begin
      nxt_cnt = 16'h0000;
      nxt_level = 1'b0;
    end
    else if (cnt_ff >= limit)
    begin
      nxt_level = 1'b1;
    end
    else
    begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cnt_ff <= 16'h0000;
      level_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;

  // Level only rises after a full unbroken count
  deb_wait_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!level_ff && !raw) |=> !level_ff)
    else $error("debounce output rose without a held condition");

endmodule

// >>> verilog/pfrl_pwm_gen.sv
// Period counter that shapes one duty-cycle code on the line.
// Assumes period and high time are stable within a period.
`timescale 1ns/100ps
module pfrl_pwm_gen (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire pfrl_pkg::pfrl_cnt_t period_cyc,
  input wire pfrl_pkg::pfrl_cnt_t high_cyc,
  // Waveform
  output logic low_phase,
  output logic period_end
);

  pfrl_pkg::pfrl_cnt_t cnt_ff;
  pfrl_pkg::pfrl_cnt_t nxt_cnt;

  // Free run within the period, wrap at the end
  always_comb
  begin
    nxt_cnt = cnt_ff + 24'h000001;
    if (!run || restart || period_end)
    begin
      nxt_cnt = 24'h000000;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cnt_ff <= 24'h000000;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
    end
  end

  // High first, then low for the rest of the period
  assign period_end = run && (cnt_ff >= period_cyc - 24'h000001);
  assign low_phase = run && (cnt_ff >= high_cyc);

endmodule

// >>> dv/pfrl_mcu_model.sv
// Microcontroller on the fault line: measures high time, acknowledges.
// Assumes the line is resolved outside the model with a pull-up.
`timescale 1ns/100ps
module pfrl_mcu_model #(
  parameter int HOLD_CYC = 420
) (
  // Clock
  input wire logic clk_sys,
  // Line
  input wire logic line,
  output logic pull,
  // Control and results
  input wire logic ack_req,
  output logic ack_busy,
  output int hi_len,
  output int fall_cnt
);
  logic prev;
  int run;
  int left;

  // Quiet start, line released
  initial
  begin
    pull = 1'b0;
    ack_busy = 1'b0;
    hi_len = 0;
    fall_cnt = 0;
    prev = 1'b1;
    run = 0;
    left = 0;
  end

  // Duty measure on each falling edge; hold low longer than any period
  always @(posedge clk_sys)
  begin
    prev <= line;
    run <= (line === 1'b1) ? run + 1 : 0;
    if (prev === 1'b1 && line === 1'b0)
    begin
      hi_len <= run;
      fall_cnt <= fall_cnt + 1;
      if (ack_req && !ack_busy)
      begin
        pull <= 1'b1;
        ack_busy <= 1'b1;
        left <= HOLD_CYC; // Margin covers the device's input sync
      end
    end
    if (ack_busy)
    begin
      left <= left - 1;
      if (left == 1)
      begin
        pull <= 1'b0;
        ack_busy <= 1'b0;
      end
    end
  end
endmodule

// >>> dv/test_pwm_fault_report_link.sv
// Testbench of the fault report link with a microcontroller model.
// Assumes short periods via parameters; the line has a pull-up.
`timescale 1ns/100ps
`include "pfrl_defs.svh"
module test_pwm_fault_report_link;
  localparam int SP = 400;
  localparam int FP = 200;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic req = 1'b0;
  logic we_r = 1'b0;
  logic [7:0] adr_r = 8'h00;
  logic [31:0] dat_r = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [9:0] flt = 10'h000;
  logic supply_on = 1'b1;
  logic drv_en = 1'b1;
  logic line;
  logic oe;
  logic pull;
  logic ack_req = 1'b0;
  logic ack_busy;
  logic gate_drive_en;
  logic [31:0] rd;
  int hi_len;
  int fall_cnt;
  int err_total = 0;
  int total_checks = 0;
  int duty [0:10] = '{`PFRL_DUTY_GSH, `PFRL_DUTY_BOOST, `PFRL_DUTY_GSL, `PFRL_DUTY_GSUP,
    `PFRL_DUTY_OVT, `PFRL_DUTY_MSL, `PFRL_DUTY_MSH, `PFRL_DUTY_LSL, `PFRL_DUTY_MEM,
    `PFRL_DUTY_DS, `PFRL_DUTY_EOF};

  // Open-drain line with pull-up
  assign line = ~(oe | pull);

  always #4 clk_sys = ~clk_sys;

  pfrl_link #(.SLOW_PERIOD_CYC(SP), .FAST_PERIOD_CYC(FP)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we_r),
    .wb_adr_i(adr_r), .wb_sel_i(4'hf), .wb_dat_i(dat_r), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .gate_supply_high(flt[0]), .boost_supply_low(flt[1]),
    .gate_source_low(flt[2]), .gate_supply_low(flt[3]), .overtemp_warning(flt[4]),
    .main_supply_low(flt[5]), .main_supply_high(flt[6]), .logic_supply_low(flt[7]),
    .config_mem_double_error(flt[8]), .drain_source_fault(flt[9]),
    .logic_supply_on(supply_on), .driver_enable_in(drv_en), .diag_line_i(line),
    .diag_line_o(), .diag_line_oe(oe), .gate_drive_en(gate_drive_en));

  pfrl_mcu_model #(.HOLD_CYC(420)) mcu_u (
    .clk_sys(clk_sys), .line(line), .pull(pull), .ack_req(ack_req),
    .ack_busy(ack_busy), .hi_len(hi_len), .fall_cnt(fall_cnt));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_sys);
    req <= 1'b1;
    we_r <= we;
    adr_r <= adr;
    dat_r <= dat;
    // No cycle limit here; only the watchdog ends a hung access
    do
    begin
      @(posedge clk_sys);
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    req <= 1'b0;
  endtask

  // High time ending at the second falling edge seen from now
  task automatic meas(input int exp, input string what);
    int f0;
    f0 = fall_cnt;
    while (fall_cnt < f0 + 2)
      @(posedge clk_sys);
    chk(what, hi_len, exp);
  endtask

  task automatic ack();
    ack_req <= 1'b1;
    while (ack_busy !== 1'b1)
      @(posedge clk_sys);
    ack_req <= 1'b0;
    while (ack_busy === 1'b1)
      @(posedge clk_sys);
  endtask

  task automatic idle_chk(input int p);
    int f0;
    f0 = fall_cnt;
    repeat (2 * p) @(posedge clk_sys);
    chk("idle", {fall_cnt == f0, line}, 2'b11);
  endtask

  task automatic t_reset();
    wb(1'b0, `PFRL_ADR_CONFIG, 32'h0);
    chk("cfg_reset", rd, `PFRL_CFG_RESET);
    wb(1'b0, 8'h08, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1'b0, `PFRL_ADR_STATUS, 32'h0);
    chk("status_idle", rd, 32'h00200000);
    chk("line_idle", line, 1'b1);
    chk("drive_on", gate_drive_en, 1'b1);
    $display("test reset done");
  endtask

  // Memory error at slow rate, repeated, then end of frame
  task automatic t_mem_slow();
    flt[8] <= 1'b1;
    meas(SP * duty[8] / 1000, "mem");
    meas(SP * duty[8] / 1000, "mem_rep");
    ack();
    flt[8] <= 1'b0;
    meas(SP * duty[10] / 1000, "eof_slow");
    ack();
    idle_chk(SP);
    $display("test mem_slow done");
  endtask

  // All faults at fast rate, sent in priority order; the memory error
  // has no debounce, so it is raised late to wait behind the running code
  task automatic t_all();
    wb(1'b1, `PFRL_ADR_CONFIG, 32'h77);
    flt <= 10'h2ff;
    repeat (2100) @(posedge clk_sys);
    flt[8] <= 1'b1;
    chk("drive_trip", gate_drive_en, 1'b0);
    for (int i = 0; i < 10; i++)
    begin
      meas(FP * duty[i] / 1000, "code");
      ack();
      if (i == 0)
        chk("drive_back", gate_drive_en, 1'b1);
    end
    meas(FP * duty[10] / 1000, "eof");
    ack();
    meas(FP * duty[10] / 1000, "eof_again");
    flt <= 10'h000;
    ack();
    idle_chk(FP);
    $display("test all_faults done");
  endtask

  // Masked monitors and short glitches give no report
  task automatic t_mask();
    wb(1'b1, `PFRL_ADR_CONFIG, 32'h71);
    wb(1'b0, `PFRL_ADR_CONFIG, 32'h0);
    chk("cfg_readback", rd, 32'h71);
    flt[9] <= 1'b1;
    flt[2] <= 1'b1;
    repeat (2)
    begin
      flt[4] <= 1'b1;
      repeat (240) @(posedge clk_sys);
      flt[4] <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    idle_chk(FP);
    flt <= 10'h000;
    $display("test mask done");
  endtask

  // Sleep low is not a report to the controller
  task automatic t_sleep();
    supply_on <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("sleep", {line, gate_drive_en}, 2'b00);
    supply_on <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("wake", {line, gate_drive_en}, 2'b11);
    drv_en <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("en_low", gate_drive_en, 1'b0);
    drv_en <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("en_high", gate_drive_en, 1'b1);
    $display("test sleep done");
  endtask

  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (10) @(posedge clk_sys);
    t_reset();
    t_mem_slow();
    t_all();
    t_mask();
    t_sleep();
    end_of_test();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    end_of_test();
  end
endmodule
